// ==== shared/ads_consts.svh ====
// Register map, field positions, reset values and timing counts of the sample/convert sequencer
// How it works
// - Software setting sample_active_bit with auto sampling off starts sampling.
// - Trigger source 000: software clearing sample_active_bit ends sampling, starts conversion.
// - Manual mode: after conversion, no sampling until software sets sample_active_bit.
// - Auto sample enable: hardware sets sample_active_bit and resamples after each conversion.
// - Auto sampling continues on the next selected input channel.
// - Falling sample_active_bit at end of sampling clears the done bit.
// - sample_active_bit 0 with done 1 means idle.
// - Clearing auto sample enable finishes the current sequence, then stops resampling.
// - Trigger source select field, control register one bits 7:5, picks end-of-sample event; only 000 and 111 are built, other values make a clear abort sampling.
// - Trigger source 111: count sample_time_count conversion clocks, then convert.
// - Trigger 111 plus auto sample enable repeats sample/convert without software.
// - Conversion clock from RC oscillator or instruction clock divided by 8-bit divider.
// - Each conversion takes exactly twelve conversion clock periods.
// - Done bit is bit 0 of control register one.
// - Clearing module_on_bit mid-conversion aborts it; result buffer keeps old value.
`ifndef ADS_CONSTS_SVH
`define ADS_CONSTS_SVH

`define ADS_OFF_CTRL1 8'h00
`define ADS_OFF_CTRL3 8'h04
`define ADS_OFF_CHAN 8'h08
`define ADS_OFF_RESULT 8'h0c
`define ADS_OFF_STATUS 8'h10
`define ADS_OFF_CLEAR 8'h14
`define ADS_OFF_ENABLE 8'h18
`define ADS_BUF_SEL 2'h1

`define ADS_BIT_ON 15
`define ADS_TRIG_HI 7
`define ADS_TRIG_LO 5
`define ADS_BIT_AUTO 2
`define ADS_BIT_SACT 1
`define ADS_BIT_DONE 0
`define ADS_SMPT_HI 12
`define ADS_SMPT_LO 8
`define ADS_BIT_RCSEL 15
`define ADS_DIV_HI 7
`define ADS_DIV_LO 0
`define ADS_CH_BASE_HI 3
`define ADS_CH_BASE_LO 0
`define ADS_BIT_SCAN 8
`define ADS_CH_LAST_HI 15
`define ADS_CH_LAST_LO 12

`define ADS_EV_DONE 0
`define ADS_EV_SAMPLE 1
`define ADS_EV_ABORT 2
`define ADS_EV_W 3

`define ADS_TRIG_MANUAL 3'h0
`define ADS_TRIG_CLOCKED 3'h7
`define ADS_RST_DIV 8'h00
`define ADS_RST_SMPT 5'h01
`define ADS_CONV_TADS 4'hc
`define ADS_SAR_STEPS 4'ha

`endif

// ==== shared/ads_pkg.sv ====
// Types shared by the sample/convert sequencer modules
`default_nettype none
package ads_pkg;
  typedef enum logic [1:0] {ADS_IDLE, ADS_SAMPLE, ADS_CONVERT} ads_state_e;
  typedef logic [9:0] ads_result_t;

  // Next channel in the scan range, wrapping back to the base
  function automatic logic [3:0] ads_next_chan(input logic [3:0] cur, input logic [3:0] base,
                                               input logic [3:0] last, input logic scan);
    if (!scan || cur == last) begin
      return base;
    end
    return 4'(cur + 4'h1);
  endfunction : ads_next_chan
endpackage : ads_pkg
`default_nettype wire

// ==== shared/ads_mem_if.sv ====
// Write and read port bundle between the sequencer and its result buffer
`timescale 1ns/1ps
`default_nettype none
interface ads_mem_if #(parameter int AW = 4, parameter int DW = 10) ();
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
  modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
endinterface : ads_mem_if
`default_nettype wire

// ==== rtl/ads_result_mem.sv ====
// Result buffer with registered read data
`timescale 1ns/1ps
`default_nettype none
module ads_result_mem #(
  parameter int AW = 4,
  parameter int DW = 10
) (
  input wire logic clk,  // System clock
  ads_mem_if.mem port    // Write and read port
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // Only whole conversions arrive here, so an aborted one never lands
  always_ff @(posedge clk) begin
    if (port.wr_en) begin
      mem[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    port.rd_data <= mem[port.rd_addr];
  end
endmodule : ads_result_mem
`default_nettype wire

// ==== rtl/ads_tad_gen.sv ====
// Conversion clock tick generator
`timescale 1ns/1ps
`default_nettype none
module ads_tad_gen #(
  parameter int DIV_W = 8
) (
  input wire logic clk,              // System clock
  input wire logic sys_rst,          // Async reset, active high
  input wire logic run,              // Module on
  input wire logic rc_sel,           // Use RC oscillator ticks
  input wire logic rc_tick,          // RC oscillator tick, one cycle
  input wire logic [DIV_W-1:0] div,  // Period is div+1 clocks
  output logic tad_tick              // One-cycle tick per conversion clock
);
  logic [DIV_W-1:0] cnt;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= '0;
      tad_tick <= 1'b0;
    end else if (!run) begin
      cnt <= '0;
      tad_tick <= 1'b0;
    end else if (rc_sel) begin
      cnt <= '0;
      tad_tick <= rc_tick;
    end else if (cnt >= div) begin
      cnt <= '0;
      tad_tick <= 1'b1;
    end else begin
      cnt <= DIV_W'(cnt + 1'b1);
      tad_tick <= 1'b0;
    end
  end
endmodule : ads_tad_gen
`default_nettype wire

// ==== rtl/ads_seq_top.sv ====
// Sample/convert sequencer of a 10-bit SAR converter with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "ads_consts.svh"
module ads_seq_top #(
  parameter int DIV_W = 8,
  parameter int CH_W = 4
) (
  input wire logic clk,                      // 20 MHz instruction clock
  input wire logic sys_rst,                  // Async reset, active high
  input wire logic psel,                     // APB select
  input wire logic penable,                  // APB enable
  input wire logic pwrite,                   // APB write
  input wire logic [7:0] paddr,              // APB byte address
  input wire logic [31:0] pwdata,            // APB write data
  output logic [31:0] prdata,                // APB read data
  output logic pready,                       // APB ready
  output logic pslverr,                      // APB error
  input wire logic rc_tick,                  // Internal RC oscillator tick
  input wire logic comp_in,                  // Comparator: input above DAC
  output logic sample_en,                    // Sample switch closed
  output logic [CH_W-1:0] chan_sel,          // Selected input channel
  output ads_pkg::ads_result_t dac_code,     // SAR trial code
  output logic irq                           // Interrupt, level
);
  import ads_pkg::*;

  // Configuration
  logic module_on;
  logic [2:0] trig_src;
  logic auto_sample_enable;
  logic [4:0] sample_time_count;
  logic rc_sel;
  logic [DIV_W-1:0] conversion_clock_divider;
  logic [CH_W-1:0] chan_base;
  logic [CH_W-1:0] chan_last;
  logic scan_en;
  logic [`ADS_EV_W-1:0] int_enable;
  logic [`ADS_EV_W-1:0] int_status;

  // Sequencer state
  ads_state_e state;
  ads_state_e prev_state;
  logic sample_active_bit;
  logic done_bit;
  logic [4:0] smp_cnt;
  logic [3:0] conv_cnt;
  logic [CH_W-1:0] cur_chan;
  ads_result_t sar_mask;
  ads_result_t last_result;

  // Bus decode
  logic apb_acc;
  logic apb_wr;
  logic ctrl1_wr;
  logic sw_start;
  logic sw_stop;
  logic mapped;
  logic [31:0] rd_value;

  // Sequencer decisions
  logic tad_tick;
  logic [4:0] smp_target;
  logic end_sample;
  logic abort_sample;
  logic conv_finish;
  logic [`ADS_EV_W-1:0] events;

  ads_mem_if #(.AW(CH_W), .DW(10)) mem_bus ();

  ads_result_mem #(.AW(CH_W), .DW(10)) i_ads_result_mem (
    .clk(clk),
    .port(mem_bus.mem)
  );

  ads_tad_gen #(.DIV_W(DIV_W)) i_ads_tad_gen (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(module_on),
    .rc_sel(rc_sel),
    .rc_tick(rc_tick),
    .div(conversion_clock_divider),
    .tad_tick(tad_tick)
  );

  // Writes take effect on the edge where pready is seen high
  assign apb_acc = psel && penable;
  assign apb_wr = apb_acc && pready && pwrite;
  assign ctrl1_wr = apb_wr && (paddr == `ADS_OFF_CTRL1);
  // Start and stop requests count only while the module is on
  assign sw_start = ctrl1_wr && module_on && pwdata[`ADS_BIT_SACT];
  assign sw_stop = ctrl1_wr && module_on && !pwdata[`ADS_BIT_SACT];

  // A zero count would wrap and sample for 32 periods, so it acts as one period
  assign smp_target = (sample_time_count == 5'h00) ? 5'h01 : sample_time_count;

  always_comb begin
    end_sample = 1'b0;
    abort_sample = 1'b0;
    if (state == ADS_SAMPLE && module_on) begin
      if (trig_src == `ADS_TRIG_CLOCKED) begin
        end_sample = tad_tick && (smp_cnt == 5'(smp_target - 5'h01));
        abort_sample = sw_stop && !end_sample;
      end else if (trig_src == `ADS_TRIG_MANUAL) begin
        end_sample = sw_stop;
      end else begin
        // Other trigger sources are not built here; a clear only aborts
        abort_sample = sw_stop;
      end
    end
  end

  assign conv_finish = module_on && (state == ADS_CONVERT) && tad_tick &&
                       (conv_cnt == 4'(`ADS_CONV_TADS - 4'h1));

  // Configuration registers; trigger source is taken as written
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      module_on <= 1'b0;
      trig_src <= `ADS_TRIG_MANUAL;
      auto_sample_enable <= 1'b0;
      sample_time_count <= `ADS_RST_SMPT;
      rc_sel <= 1'b0;
      conversion_clock_divider <= DIV_W'(`ADS_RST_DIV);
      chan_base <= '0;
      chan_last <= '0;
      scan_en <= 1'b0;
      int_enable <= '0;
    end else if (apb_wr) begin
      case (paddr)
        `ADS_OFF_CTRL1: begin
          module_on <= pwdata[`ADS_BIT_ON];
          trig_src <= pwdata[`ADS_TRIG_HI:`ADS_TRIG_LO];
          auto_sample_enable <= pwdata[`ADS_BIT_AUTO];
        end
        `ADS_OFF_CTRL3: begin
          sample_time_count <= pwdata[`ADS_SMPT_HI:`ADS_SMPT_LO];
          rc_sel <= pwdata[`ADS_BIT_RCSEL];
          conversion_clock_divider <= pwdata[`ADS_DIV_LO+DIV_W-1:`ADS_DIV_LO];
        end
        `ADS_OFF_CHAN: begin
          chan_base <= pwdata[`ADS_CH_BASE_LO+CH_W-1:`ADS_CH_BASE_LO];
          chan_last <= pwdata[`ADS_CH_LAST_LO+CH_W-1:`ADS_CH_LAST_LO];
          scan_en <= pwdata[`ADS_BIT_SCAN];
        end
        `ADS_OFF_ENABLE: begin
          int_enable <= pwdata[`ADS_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Sample/convert sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ADS_IDLE;
      sample_active_bit <= 1'b0;
      done_bit <= 1'b1;
      smp_cnt <= '0;
      conv_cnt <= '0;
      cur_chan <= '0;
    end else if (!module_on) begin
      // Abort anything in flight and rest in the idle pattern
      state <= ADS_IDLE;
      sample_active_bit <= 1'b0;
      done_bit <= 1'b1;
      smp_cnt <= '0;
      conv_cnt <= '0;
      cur_chan <= chan_base;
    end else begin
      if (ctrl1_wr) begin
        sample_active_bit <= pwdata[`ADS_BIT_SACT];
      end
      case (state)
        ADS_IDLE: begin
          // Stays here after a manual conversion until a new start
          if (sw_start || sample_active_bit || auto_sample_enable) begin
            state <= ADS_SAMPLE;
            sample_active_bit <= 1'b1;
            smp_cnt <= '0;
            cur_chan <= chan_base;
          end
        end
        ADS_SAMPLE: begin
          if (end_sample) begin
            state <= ADS_CONVERT;
            sample_active_bit <= 1'b0;
            done_bit <= 1'b0;
            conv_cnt <= '0;
          end else if (abort_sample) begin
            state <= ADS_IDLE;
          end else if (tad_tick) begin
            smp_cnt <= 5'(smp_cnt + 5'h01);
          end
        end
        ADS_CONVERT: begin
          if (conv_finish) begin
            done_bit <= 1'b1;
            conv_cnt <= '0;
            // Enable is read at the end, so clearing it lets this one finish
            if (auto_sample_enable) begin
              state <= ADS_SAMPLE;
              sample_active_bit <= 1'b1;
              smp_cnt <= '0;
              cur_chan <= ads_next_chan(cur_chan, chan_base, chan_last, scan_en);
            end else begin
              state <= ADS_IDLE;
            end
          end else if (tad_tick) begin
            conv_cnt <= 4'(conv_cnt + 4'h1);
          end
        end
        default: begin
          state <= ADS_IDLE;
        end
      endcase
    end
  end

  // Successive approximation, one bit per conversion clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dac_code <= '0;
      sar_mask <= '0;
    end else if (end_sample) begin
      dac_code <= 10'h200;
      sar_mask <= 10'h200;
    end else if (module_on && state == ADS_CONVERT && tad_tick &&
                 conv_cnt < `ADS_SAR_STEPS) begin
      dac_code <= (comp_in ? dac_code : (dac_code & ~sar_mask)) | (sar_mask >> 1);
      sar_mask <= sar_mask >> 1;
    end
  end

  // Result lands in the buffer slot of its channel on the finishing edge
  assign mem_bus.wr_en = conv_finish;
  assign mem_bus.wr_addr = cur_chan;
  assign mem_bus.wr_data = dac_code;
  assign mem_bus.rd_addr = paddr[CH_W+1:2];

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      last_result <= '0;
    end else if (conv_finish) begin
      last_result <= dac_code;
    end
  end

  // Pin outputs follow the state one cycle later
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_en <= 1'b0;
      chan_sel <= '0;
      prev_state <= ADS_IDLE;
    end else begin
      sample_en <= (state == ADS_SAMPLE);
      chan_sel <= cur_chan;
      prev_state <= state;
    end
  end

  // Events: completion, start of sampling, abort by switching off
  always_comb begin
    events = '0;
    events[`ADS_EV_DONE] = conv_finish;
    events[`ADS_EV_SAMPLE] = (state == ADS_SAMPLE) && (prev_state != ADS_SAMPLE);
    events[`ADS_EV_ABORT] = ctrl1_wr && module_on && !pwdata[`ADS_BIT_ON] &&
                            (state != ADS_IDLE);
  end

  // Set wins over a clear written in the same cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_status <= '0;
    end else if (apb_wr && paddr == `ADS_OFF_CLEAR) begin
      int_status <= (int_status & ~pwdata[`ADS_EV_W-1:0]) | events;
    end else begin
      int_status <= int_status | events;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status & int_enable);
    end
  end

  // Read mux; buffer data arrive one cycle after the address
  always_comb begin
    rd_value = '0;
    mapped = 1'b1;
    if (paddr[7:6] == `ADS_BUF_SEL && paddr[1:0] == 2'h0) begin
      rd_value[9:0] = mem_bus.rd_data;
    end else begin
      case (paddr)
        `ADS_OFF_CTRL1: begin
          rd_value[`ADS_BIT_ON] = module_on;
          rd_value[`ADS_TRIG_HI:`ADS_TRIG_LO] = trig_src;
          rd_value[`ADS_BIT_AUTO] = auto_sample_enable;
          rd_value[`ADS_BIT_SACT] = sample_active_bit;
          rd_value[`ADS_BIT_DONE] = done_bit;
        end
        `ADS_OFF_CTRL3: begin
          rd_value[`ADS_SMPT_HI:`ADS_SMPT_LO] = sample_time_count;
          rd_value[`ADS_BIT_RCSEL] = rc_sel;
          rd_value[`ADS_DIV_LO+DIV_W-1:`ADS_DIV_LO] = conversion_clock_divider;
        end
        `ADS_OFF_CHAN: begin
          rd_value[`ADS_CH_BASE_LO+CH_W-1:`ADS_CH_BASE_LO] = chan_base;
          rd_value[`ADS_CH_LAST_LO+CH_W-1:`ADS_CH_LAST_LO] = chan_last;
          rd_value[`ADS_BIT_SCAN] = scan_en;
        end
        `ADS_OFF_RESULT: rd_value[9:0] = last_result;
        `ADS_OFF_STATUS: rd_value[`ADS_EV_W-1:0] = int_status;
        `ADS_OFF_CLEAR: rd_value = '0;
        `ADS_OFF_ENABLE: rd_value[`ADS_EV_W-1:0] = int_enable;
        default: mapped = 1'b0;
      endcase
    end
  end

  // One wait state on every access keeps buffer reads and register reads alike
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (apb_acc && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr <= !mapped;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule : ads_seq_top
`default_nettype wire

// ==== sim/ads_seq_top_props.sv ====
// Port-level checks of the sample/convert sequencer, bound into its top module
`timescale 1ns/1ps
`default_nettype none
module ads_seq_top_props #(
  parameter int DIV_W = 8,
  parameter int CH_W = 4
) (
  input wire logic clk,                    // Clock
  input wire logic sys_rst,                // Async reset
  input wire logic psel,                   // APB select
  input wire logic penable,                // APB enable
  input wire logic pwrite,                 // APB write
  input wire logic [7:0] paddr,            // APB address
  input wire logic [31:0] pwdata,          // APB write data
  input wire logic [31:0] prdata,          // APB read data
  input wire logic pready,                 // APB ready
  input wire logic pslverr,                // APB error
  input wire logic rc_tick,                // RC tick
  input wire logic comp_in,                // Comparator
  input wire logic sample_en,              // Sampling
  input wire logic [CH_W-1:0] chan_sel,    // Channel
  input wire ads_pkg::ads_result_t dac_code, // Trial code
  input wire logic irq                     // Interrupt
);
  import ads_pkg::*;
  logic wr;
  logic on_q;
  logic en_q;
  logic ab_wr;
  assign wr = psel && penable && pready && pwrite;
  // Module off, or a start clear under a non-manual trigger, ends sampling early
  assign ab_wr = wr && paddr == 8'h00 && (!pwdata[15] || (pwdata[7:5] != 3'h0 && !pwdata[1]));
  // Shadow of module on, taken at the same edge as the register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      on_q <= 1'b0;
    end else if (wr && paddr == 8'h00) begin
      on_q <= pwdata[15];
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= 1'b0;
    end else if (wr && paddr == 8'h18) begin
      en_q <= |pwdata[2:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  wait_state_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  err_unmapped_a: assert property (psel && penable && !pready && paddr == 8'h30 |=> pslverr)
    else $error("unmapped access not refused");
  off_idle_a: assert property (!on_q [*3] |-> !sample_en)
    else $error("sampling while module off");
  off_abort_a: assert property (wr && paddr == 8'h00 && !pwdata[15] |-> ##[1:3] !sample_en)
    else $error("module off did not stop sampling");
  manual_end_a: assert property (wr && paddr == 8'h00 && pwdata[15] && pwdata[7:5] == 3'h0 &&
    !pwdata[2] && !pwdata[1] && sample_en |-> ##[1:3] !sample_en)
    else $error("software clear did not end sampling");
  manual_start_a: assert property (wr && paddr == 8'h00 && on_q && pwdata[15] && pwdata[1] &&
    !pwdata[2] && !sample_en |-> ##[1:3] sample_en)
    else $error("software set did not start sampling");
  conv_gap_a: assert property ($fell(sample_en) && !$past(ab_wr, 2) && !$past(ab_wr, 3) |->
    !sample_en [*8])
    else $error("sampling restarted inside a conversion");
  irq_masked_a: assert property (!en_q && !$past(en_q) |-> !irq)
    else $error("interrupt while masked");
endmodule : ads_seq_top_props
bind ads_seq_top ads_seq_top_props #(.DIV_W(DIV_W), .CH_W(CH_W)) i_props (.clk(clk),
  .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rc_tick(rc_tick),
  .comp_in(comp_in), .sample_en(sample_en), .chan_sel(chan_sel), .dac_code(dac_code),
  .irq(irq));
`default_nettype wire

// ==== sim/ads_seq_top_tb.sv ====
// Self-checking testbench of the sample/convert sequencer
`timescale 1ns/1ps
`default_nettype none
module ads_seq_top_tb;
  import ads_pkg::*;
  logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, rc_tick = 0, comp_in = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sample_en, irq, er;
  logic [3:0] chan_sel;
  ads_result_t dac_code;
  int n_mismatch = 0, comparisons = 0, cyc = 0, rc_cnt = 0;
  ads_seq_top i_ads_seq_top (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_tick(rc_tick), .comp_in(comp_in), .sample_en(sample_en),
    .chan_sel(chan_sel), .dac_code(dac_code), .irq(irq));
  always #25 clk = ~clk;
  // RC ticks every 5 clocks; also the hang guard
  always @(posedge clk) begin
    rc_cnt <= (rc_cnt == 4) ? 0 : rc_cnt + 1;
    rc_tick <= (rc_cnt == 4);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask : rdc
  task automatic meas(output int hi);
    while (sample_en !== 1'b1) @(posedge clk);
    hi = 0;
    while (sample_en === 1'b1) begin
      hi++;
      @(posedge clk);
    end
  endtask : meas
  task automatic t_reset();
    rdc("ctrl1", 8'h00, 32'h1);
    rdc("ctrl3", 8'h04, 32'h100);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", {31'h0, er}, 32'h1);
  endtask : t_reset
  task automatic t_manual();
    comp_in <= 1'b1;
    apb(1'b1, 8'h18, 32'h1);
    apb(1'b1, 8'h08, 32'h0);
    apb(1'b1, 8'h00, 32'h8000);
    apb(1'b1, 8'h00, 32'h8002);
    rdc("sampling", 8'h00, 32'h8003);
    @(negedge clk);
    chk("sample_en", {31'h0, sample_en}, 32'h1);
    apb(1'b1, 8'h00, 32'h8000);
    rdc("converting", 8'h00, 32'h8000);
    while (irq !== 1'b1) @(posedge clk);
    rdc("idle", 8'h00, 32'h8001);
    rdc("result", 8'h0c, 32'h3ff);
    rdc("slot", 8'h40, 32'h3ff);
    chk("dac code", {22'h0, dac_code}, 32'h3ff);
    chk("no resample", {31'h0, sample_en}, 32'h0);
    apb(1'b1, 8'h18, 32'h0);
    repeat (2) @(negedge clk);
    chk("masked irq", {31'h0, irq}, 32'h0);
    rdc("status", 8'h10, 32'h3);
    apb(1'b1, 8'h14, 32'h7);
    rdc("cleared", 8'h10, 32'h0);
    apb(1'b1, 8'h18, 32'h1);
  endtask : t_manual
  task automatic t_abort();
    comp_in <= 1'b0;
    apb(1'b1, 8'h00, 32'h8002);
    apb(1'b1, 8'h00, 32'h8000);
    apb(1'b1, 8'h00, 32'h0);
    rdc("kept result", 8'h0c, 32'h3ff);
    rdc("kept slot", 8'h40, 32'h3ff);
    rdc("abort flag", 8'h10, 32'h6);
    apb(1'b1, 8'h00, 32'h2);
    repeat (3) @(negedge clk);
    chk("off sample", {31'h0, sample_en}, 32'h0);
    rdc("off idle", 8'h00, 32'h1);
    apb(1'b1, 8'h00, 32'h8020);
    apb(1'b1, 8'h00, 32'h8022);
    apb(1'b1, 8'h00, 32'h8020);
    rdc("other trig", 8'h00, 32'h8021);
    rdc("no convert", 8'h10, 32'h6);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h14, 32'h7);
  endtask : t_abort
  task automatic t_auto();
    int hi;
    int lo;
    logic [3:0] prev;
    logic [3:0] nxt;
    apb(1'b1, 8'h08, 32'h4102);
    apb(1'b1, 8'h04, 32'h300);
    apb(1'b1, 8'h00, 32'h80e4);
    meas(hi);
    prev = chan_sel;
    for (int i = 0; i < 4; i++) begin
      chk("sample len", 32'(hi), 32'h3);
      lo = 0;
      while (sample_en !== 1'b1) begin
        lo++;
        @(posedge clk);
      end
      chk("conv len", {31'h0, lo == 12 || lo == 13}, 32'h1);
      nxt = (prev == 4'h4) ? 4'h2 : prev + 4'h1;
      chk("next chan", {28'h0, chan_sel}, {28'h0, nxt});
      prev = chan_sel;
      meas(hi);
    end
    // Drop auto while converting: this conversion must still finish
    apb(1'b1, 8'h00, 32'h80e0);
    lo = 0;
    repeat (40) begin
      @(posedge clk);
      lo += 32'(sample_en);
    end
    chk("no restart", 32'(lo), 32'h0);
    rdc("finished", 8'h00, 32'h80e1);
    rdc("result", 8'h0c, 32'h0);
  endtask : t_auto
  task automatic t_clock();
    int hi;
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h202);
    apb(1'b1, 8'h00, 32'h80e0);
    apb(1'b1, 8'h00, 32'h80e2);
    meas(hi);
    chk("div tad", {31'h0, hi >= 4 && hi <= 6}, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h04, 32'h8200);
    apb(1'b1, 8'h00, 32'h80e0);
    apb(1'b1, 8'h00, 32'h80e2);
    meas(hi);
    chk("rc tad", {31'h0, hi >= 6 && hi <= 10}, 32'h1);
  endtask : t_clock
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_manual();
    t_abort();
    t_auto();
    t_clock();
    report_and_stop();
  end
endmodule : ads_seq_top_tb
`default_nettype wire
